// ---- core/tm3_core.sv ----
// third 16-bit timer/counter: counting, capture/reload, baud ticks, interrupt.
// assumes pins synchronous to aclk; aclk stands in for the oscillator.
//
// Chosen here: the AXI4-Lite slave port.
`default_nettype none
module tm3_core
  import tm3_pkg::*;
(
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  input  wire logic              ext_count_pin,
  input  wire logic              ext_trigger_pin,
  input  wire logic              timer1_ovf_tick,
  output logic                   rx_baud_tick,
  output logic                   tx_baud_tick,
  output logic                   timer_out,
  output logic                   irq
);
  typedef struct packed {
    logic [3:0]  div_cnt;
    logic        cnt_prev;
    logic        trig_prev;
    logic [7:0]  ctrl;
    logic [1:0]  mode;
    logic [15:0] count;
    logic [15:0] reload;
    logic [1:0]  irq_stat;
    logic [1:0]  irq_mask;
    logic        six_clk;
    logic        rx_tick;
    logic        tx_tick;
    logic        tmr_out;
    logic        irq;
  } tm3_core_s;

  tm3_core_s s_q, s_d;

  tm3_reg_if rb ();

  tm3_axil u_axil (
    .aclk    (aclk),
    .aresetn (aresetn),
    .awaddr  (s_axi_awaddr),
    .awvalid (s_axi_awvalid),
    .awready (s_axi_awready),
    .wdata   (s_axi_wdata),
    .wstrb   (s_axi_wstrb),
    .wvalid  (s_axi_wvalid),
    .wready  (s_axi_wready),
    .bresp   (s_axi_bresp),
    .bvalid  (s_axi_bvalid),
    .bready  (s_axi_bready),
    .araddr  (s_axi_araddr),
    .arvalid (s_axi_arvalid),
    .arready (s_axi_arready),
    .rdata   (s_axi_rdata),
    .rresp   (s_axi_rresp),
    .rvalid  (s_axi_rvalid),
    .rready  (s_axi_rready),
    .rb      (rb)
  );

  // address decode, shared by the read and the write path
  function automatic logic idx_mapped(input logic [IDX_W-1:0] idx);
    idx_mapped = (idx >= IDX_CTRL) && (idx <= IDX_CONFIG);
  endfunction : idx_mapped

  // byte-lane merge for the 16-bit registers
  function automatic logic [15:0] merge16(input logic [15:0] cur,
                                          input logic [31:0] wd,
                                          input logic [3:0]  st);
    merge16 = {st[1] ? wd[15:8] : cur[15:8], st[0] ? wd[7:0] : cur[7:0]};
  endfunction : merge16

  assign rb.wr_hit = idx_mapped(rb.wr_idx);
  assign rb.rd_hit = idx_mapped(rb.rd_idx);

  // read mux; unimplemented mode bits read as zero
  always_comb begin
    rb.rd_data = 32'h0000_0000;
    case (rb.rd_idx)
      IDX_CTRL:     rb.rd_data[7:0]  = s_q.ctrl;
      IDX_MODE:     rb.rd_data[1:0]  = s_q.mode;
      IDX_IRQ_STAT: rb.rd_data[1:0]  = s_q.irq_stat;
      IDX_IRQ_MASK: rb.rd_data[1:0]  = s_q.irq_mask;
      IDX_COUNT:    rb.rd_data[15:0] = s_q.count;
      IDX_RELOAD:   rb.rd_data[15:0] = s_q.reload;
      IDX_CONFIG:   rb.rd_data[0]    = s_q.six_clk;
      default:      rb.rd_data       = 32'h0000_0000;
    endcase
  end

  assign rx_baud_tick = s_q.rx_tick;
  assign tx_baud_tick = s_q.tx_tick;
  assign timer_out    = s_q.tmr_out;
  assign irq          = s_q.irq;

  // counting, trigger handling, register writes and flag updates
  always_comb begin
    logic        baud;
    logic        running;
    logic        tick_int;
    logic        cnt_fall;
    logic        trig_fall;
    logic        step;
    logic        down;
    logic        ovf;
    logic [3:0]  div_lim;
    logic [1:0]  ev;
    baud      = 1'b0;
    running   = 1'b0;
    tick_int  = 1'b0;
    cnt_fall  = 1'b0;
    trig_fall = 1'b0;
    step      = 1'b0;
    down      = 1'b0;
    ovf       = 1'b0;
    div_lim   = DIV_TWELVE;
    ev        = 2'b00;
    s_d       = s_q;

    baud    = s_q.ctrl[CTL_RXBAUD] | s_q.ctrl[CTL_TXBAUD];
    running = s_q.ctrl[CTL_RUN];
    // internal tick: clock over 6 or 12; prescaler holds while stopped
    div_lim = s_q.six_clk ? DIV_SIX : DIV_TWELVE;
    if (running) begin
      if (s_q.div_cnt == div_lim - 4'h1) begin
        s_d.div_cnt = 4'h0;
        tick_int    = 1'b1;
      end else begin
        s_d.div_cnt = s_q.div_cnt + 4'h1;
      end
    end

    // edge detectors on the pins, sampled every cycle
    s_d.cnt_prev  = ext_count_pin;
    s_d.trig_prev = ext_trigger_pin;
    cnt_fall      = s_q.cnt_prev & ~ext_count_pin;
    trig_fall     = s_q.trig_prev & ~ext_trigger_pin & s_q.ctrl[CTL_TRIGEN];

    // trigger pin doubles as direction when down counting is enabled and the timer is not a baud source
    step = running & (s_q.ctrl[CTL_CNTSRC] ? cnt_fall : tick_int);
    down = s_q.mode[MODE_DOWN] & ~ext_trigger_pin & ~baud;

    if (step) begin
      if (down) begin
        if (s_q.count == s_q.reload) begin
          s_d.count = COUNT_MAX;
          ovf       = 1'b1;
        end else begin
          s_d.count = s_q.count - 16'h0001;
        end
      end else if (s_q.count == COUNT_MAX) begin
        ovf = 1'b1;
        // baud use forces reload, capture mode just rolls over
        s_d.count = (s_q.ctrl[CTL_CAPSEL] && !baud) ? COUNT_ZERO : s_q.reload;
      end else begin
        s_d.count = s_q.count + 16'h0001;
      end
    end

    // trigger edge: capture or reload only when not a baud source
    if (trig_fall && !baud) begin
      if (s_q.ctrl[CTL_CAPSEL]) begin
        s_d.reload = s_q.count;
      end else begin
        s_d.count = s_q.reload;
      end
    end

    // software writes land after counting so a write wins over a step
    if (rb.wr_en) begin
      case (rb.wr_idx)
        IDX_CTRL: begin
          if (rb.wr_strb[0]) s_d.ctrl = rb.wr_data[7:0];
        end
        IDX_MODE: begin
          if (rb.wr_strb[0]) s_d.mode = rb.wr_data[1:0];
        end
        IDX_IRQ_STAT: begin
          if (rb.wr_strb[0]) s_d.irq_stat = s_q.irq_stat & ~rb.wr_data[1:0];
        end
        IDX_IRQ_MASK: begin
          if (rb.wr_strb[0]) s_d.irq_mask = rb.wr_data[1:0];
        end
        IDX_COUNT:  s_d.count  = merge16(s_d.count, rb.wr_data, rb.wr_strb);
        IDX_RELOAD: s_d.reload = merge16(s_d.reload, rb.wr_data, rb.wr_strb);
        IDX_CONFIG: begin
          if (rb.wr_strb[0]) s_d.six_clk = rb.wr_data[0];
        end
        default: s_d.six_clk = s_d.six_clk;
      endcase
    end

    // hardware sets after the write, so an event beats a same-cycle clear
    ev[IRQ_OVF]  = ovf & ~baud;
    ev[IRQ_TRIG] = trig_fall;
    if (ev[IRQ_OVF]) s_d.ctrl[CTL_OVF] = 1'b1;
    if (ev[IRQ_TRIG]) s_d.ctrl[CTL_TRIGF] = 1'b1;
    s_d.irq_stat = s_d.irq_stat | ev;

    // serial port clock selection, one-cycle ticks
    s_d.rx_tick = s_q.ctrl[CTL_RXBAUD] ? ovf : timer1_ovf_tick;
    s_d.tx_tick = s_q.ctrl[CTL_TXBAUD] ? ovf : timer1_ovf_tick;
    if (ovf && s_q.mode[MODE_OUTEN]) s_d.tmr_out = ~s_q.tmr_out;
    s_d.irq = |(s_d.irq_stat & s_d.irq_mask);
  end

  // one register for all state; reset leaves the timer stopped
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q      <= '0;
      s_q.ctrl <= CTRL_RESET;
      s_q.mode <= MODE_RESET;
    end else begin
      s_q <= s_d;
    end
  end
endmodule : tm3_core
`default_nettype wire

// ---- pkg/tm3_pkg.sv ----
// constants for the third timer/counter block and its register map.
// assumes one 250 MHz clock, used as the oscillator, and an AXI4-Lite master outside.
`default_nettype none
package tm3_pkg;
  localparam int unsigned ADDR_W = 12;
  localparam int unsigned IDX_W  = 10;
  // register indices; byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_CTRL     = 10'h0c8;
  localparam logic [IDX_W-1:0] IDX_MODE     = 10'h0c9;
  localparam logic [IDX_W-1:0] IDX_IRQ_STAT = 10'h0ca;
  localparam logic [IDX_W-1:0] IDX_IRQ_MASK = 10'h0cb;
  localparam logic [IDX_W-1:0] IDX_COUNT    = 10'h0cc;
  localparam logic [IDX_W-1:0] IDX_RELOAD   = 10'h0cd;
  localparam logic [IDX_W-1:0] IDX_CONFIG   = 10'h0ce;
  // control register fields
  localparam int unsigned CTL_OVF     = 7;
  localparam int unsigned CTL_TRIGF   = 6;
  localparam int unsigned CTL_RXBAUD  = 5;
  localparam int unsigned CTL_TXBAUD  = 4;
  localparam int unsigned CTL_TRIGEN  = 3;
  localparam int unsigned CTL_RUN     = 2;
  localparam int unsigned CTL_CNTSRC  = 1;
  localparam int unsigned CTL_CAPSEL  = 0;
  localparam logic [7:0]  CTRL_RESET  = 8'h00;
  // mode register fields
  localparam int unsigned MODE_OUTEN  = 1;
  localparam int unsigned MODE_DOWN   = 0;
  localparam logic [1:0]  MODE_RESET  = 2'h0;
  // interrupt status / mask bits
  localparam int unsigned IRQ_OVF     = 0;
  localparam int unsigned IRQ_TRIG    = 1;
  localparam logic [1:0]  IRQ_RESET   = 2'h0;
  // internal tick dividers, in clock cycles
  localparam logic [3:0]  DIV_SIX     = 4'h6;
  localparam logic [3:0]  DIV_TWELVE  = 4'hc;
  localparam logic [15:0] COUNT_MAX   = 16'hffff;
  localparam logic [15:0] COUNT_ZERO  = 16'h0000;
  localparam logic [1:0]  RESP_OKAY   = 2'b00;
  localparam logic [1:0]  RESP_SLVERR = 2'b10;
endpackage : tm3_pkg
`default_nettype wire

// ---- pkg/tm3_reg_if.sv ----
// register access path between the bus slave and the timer core.
// assumes both ends run on the same clock; wr_en is a one-cycle pulse.
`default_nettype none
interface tm3_reg_if;
  import tm3_pkg::*;
  logic             wr_en;
  logic [IDX_W-1:0] wr_idx;
  logic [31:0]      wr_data;
  logic [3:0]       wr_strb;
  logic             wr_hit;
  logic [IDX_W-1:0] rd_idx;
  logic [31:0]      rd_data;
  logic             rd_hit;
  modport bus  (output wr_en, wr_idx, wr_data, wr_strb, rd_idx, input wr_hit, rd_data, rd_hit);
  modport regs (input wr_en, wr_idx, wr_data, wr_strb, rd_idx, output wr_hit, rd_data, rd_hit);
endinterface : tm3_reg_if
`default_nettype wire

// ---- core/tm3_axil.sv ----
// AXI4-Lite slave that turns bus transfers into register strobes.
// assumes one write and one read at most under way; unmapped addresses get SLVERR.
`default_nettype none
module tm3_axil
  import tm3_pkg::*;
(
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic [ADDR_W-1:0] awaddr,
  input  wire logic              awvalid,
  output logic                   awready,
  input  wire logic [31:0]       wdata,
  input  wire logic [3:0]        wstrb,
  input  wire logic              wvalid,
  output logic                   wready,
  output logic [1:0]             bresp,
  output logic                   bvalid,
  input  wire logic              bready,
  input  wire logic [ADDR_W-1:0] araddr,
  input  wire logic              arvalid,
  output logic                   arready,
  output logic [31:0]            rdata,
  output logic [1:0]             rresp,
  output logic                   rvalid,
  input  wire logic              rready,
  tm3_reg_if.bus                 rb
);
  typedef struct packed {
    logic             aw_got;
    logic             w_got;
    logic [IDX_W-1:0] idx;
    logic [31:0]      data;
    logic [3:0]       strb;
    logic             bvalid;
    logic [1:0]       bresp;
    logic             rvalid;
    logic [1:0]       rresp;
    logic [31:0]      rdata;
  } tm3_axil_s;

  tm3_axil_s s_q, s_d;

  // address and data channels refuse while a response is pending
  assign awready    = ~s_q.aw_got & ~s_q.bvalid;
  assign wready     = ~s_q.w_got & ~s_q.bvalid;
  assign arready    = ~s_q.rvalid;
  assign bvalid     = s_q.bvalid;
  assign bresp      = s_q.bresp;
  assign rvalid     = s_q.rvalid;
  assign rresp      = s_q.rresp;
  assign rdata      = s_q.rdata;
  assign rb.wr_en   = s_q.aw_got & s_q.w_got & ~s_q.bvalid;
  assign rb.wr_idx  = s_q.idx;
  assign rb.wr_data = s_q.data;
  assign rb.wr_strb = s_q.strb;
  assign rb.rd_idx  = araddr[ADDR_W-1:2];

  // channel bookkeeping; aw and w may arrive in either order
  always_comb begin
    s_d = s_q;
    if (awvalid && awready) begin
      s_d.aw_got = 1'b1;
      s_d.idx    = awaddr[ADDR_W-1:2];
    end
    if (wvalid && wready) begin
      s_d.w_got = 1'b1;
      s_d.data  = wdata;
      s_d.strb  = wstrb;
    end
    if (rb.wr_en) begin
      s_d.aw_got = 1'b0;
      s_d.w_got  = 1'b0;
      s_d.bvalid = 1'b1;
      s_d.bresp  = rb.wr_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_q.bvalid && bready) begin
      s_d.bvalid = 1'b0;
    end
    // read data sampled at the address handshake, no read side effects
    if (arvalid && arready) begin
      s_d.rvalid = 1'b1;
      s_d.rdata  = rb.rd_data;
      s_d.rresp  = rb.rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_q.rvalid && rready) begin
      s_d.rvalid = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
endmodule : tm3_axil
`default_nettype wire

// ---- sim/tm3_core_props.sv ----
// assertion checker for the third timer block: bus handshakes and interrupt.
// assumes it is bound to tm3_core and sees only the top module's ports.
`default_nettype none
module tm3_core_props
  import tm3_pkg::*;
(
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        irq
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // write steps: both channels taken, then the answer within two edges
  sequence aw_w_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence b_answer;
    ##[1:2] s_axi_bvalid;
  endsequence
  AST_RESET_QUIET: assert property ($rose(aresetn) |-> !irq && !s_axi_bvalid && !s_axi_rvalid)
    else $error("output active right after reset");
  AST_WRITE_ANSWER: assert property (aw_w_taken |-> b_answer)
    else $error("write response late");
  AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  AST_NO_NEW_WRITE: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while response pending");
  AST_READ_ANSWER: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
  AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
  AST_SLVERR_ZERO: assert property (s_axi_rvalid && s_axi_rresp == RESP_SLVERR |-> s_axi_rdata == 32'h0000_0000)
    else $error("error read carries data");
  // a flag is never cleared by hardware, so irq only falls on a write
  AST_IRQ_SW_CLEAR: assert property ($fell(irq) |-> $rose(s_axi_bvalid))
    else $error("irq fell without a register write");
endmodule : tm3_core_props
bind tm3_core tm3_core_props u_props (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .irq);
`default_nettype wire

// ---- sim/tm3_pins_model.sv ----
// model of the pins around the timer: count pin, trigger pin, timer 1 ticks.
// assumes tasks are called just after a rising edge; count and trigger pins idle high (pull-ups).
`default_nettype none
module tm3_pins_model (
  input  wire logic aclk,
  output logic      ext_count_pin,
  output logic      ext_trigger_pin,
  output logic      timer1_ovf_tick
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    ext_count_pin = 1'b1;
    ext_trigger_pin = 1'b1;
    timer1_ovf_tick = 1'b0;
  end
  // one low cycle per event, so every edge is a clean falling edge
  task automatic falls(input int n);
    repeat (n) begin
      ext_count_pin <= 1'b0;
      @(posedge aclk);
      ext_count_pin <= 1'b1;
      @(posedge aclk);
    end
  endtask : falls
  task automatic trig_fall();
    ext_trigger_pin <= 1'b0;
    @(posedge aclk);
    ext_trigger_pin <= 1'b1;
    @(posedge aclk);
  endtask : trig_fall
  task automatic set_trig(input logic v);
    ext_trigger_pin <= v;
    @(posedge aclk);
  endtask : set_trig
  task automatic t1_pulse();
    timer1_ovf_tick <= 1'b1;
    @(posedge aclk);
    timer1_ovf_tick <= 1'b0;
    @(posedge aclk);
  endtask : t1_pulse
endmodule : tm3_pins_model
`default_nettype wire

// ---- sim/timer2_control_logic_bench.sv ----
// self-checking bench for the third timer block over AXI4-Lite.
// assumes tm3_core, its checker and the pin model are compiled before it.
`default_nettype none
module timer2_control_logic_bench
  import tm3_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct {logic [IDX_W-1:0] idx; logic [15:0] d; logic [15:0] e;} tm3_row_s;
  logic aclk = 1'b0, aresetn = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
  logic s_axi_bready = 1'b1, s_axi_rready = 1'b1; // ready except in the stall test: answers taken at once
  logic [ADDR_W-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic [1:0] s_axi_bresp, s_axi_rresp, rs;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic ext_count_pin, ext_trigger_pin, timer1_ovf_tick, rx_baud_tick, tx_baud_tick, timer_out, irq;
  int n_errors = 0, cmp_count = 0, rx_seen = 0, tx_seen = 0;
  tm3_row_s rows[8] = '{'{IDX_MODE, 16'h0003, 16'h0003}, '{IDX_IRQ_MASK, 16'h0003, 16'h0003},
    '{IDX_RELOAD, 16'h1234, 16'h1234}, '{IDX_COUNT, 16'habcd, 16'habcd}, '{IDX_CONFIG, 16'h0001, 16'h0001},
    '{IDX_CONFIG, 16'h0000, 16'h0000}, '{IDX_CTRL, 16'h0003, 16'h0003}, '{IDX_MODE, 16'h0000, 16'h0000}};
  always #2 aclk = ~aclk;
  tm3_core DUT (.*);
  tm3_pins_model pins (.aclk, .ext_count_pin, .ext_trigger_pin, .timer1_ovf_tick);
  // baud pulses are one cycle wide, so count them as they pass
  always @(posedge aclk) begin
    if (rx_baud_tick === 1'b1) rx_seen++;
    if (tx_baud_tick === 1'b1) tx_seen++;
  end
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  // write: address and data offered together, each released when taken
  task automatic wr(input logic [IDX_W-1:0] idx, input logic [15:0] d);
    s_axi_awaddr <= {idx, 2'b00};
    s_axi_wdata <= {16'h0000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
  endtask : wr
  task automatic rdr(input logic [IDX_W-1:0] idx);
    s_axi_araddr <= {idx, 2'b00};
    s_axi_arvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    rd = s_axi_rdata;
    rs = s_axi_rresp;
  endtask : rdr
  task automatic rchk(input string nm, input logic [IDX_W-1:0] idx, input logic [15:0] e);
    rdr(idx);
    chk(nm, rd, {16'h0000, e});
  endtask : rchk
  // run on internal ticks for a fixed span; the bus adds a few cycles of slack
  task automatic tick_run(input logic [15:0] cfg, input int lo, input int hi);
    logic [31:0] held;
    wr(IDX_CONFIG, cfg);
    wr(IDX_COUNT, 16'h0000);
    wr(IDX_CTRL, 16'h0004);
    repeat (120) @(posedge aclk);
    wr(IDX_CTRL, 16'h0000);
    rdr(IDX_COUNT);
    held = rd;
    chk("tick_rate", {31'h0000_0000, (rd >= lo && rd <= hi)}, 32'h0000_0001);
    repeat (40) @(posedge aclk);
    rdr(IDX_COUNT);
    chk("count_held", rd, held);
  endtask : tick_run
  task automatic tally_and_finish();
    if (n_errors == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : tally_and_finish
  initial begin
    repeat (20000) @(posedge aclk);
    n_errors++;
    tally_and_finish();
  end
  initial begin
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    rchk("ctrl_rst", IDX_CTRL, 16'h0000);
    rchk("mode_rst", IDX_MODE, 16'h0000);
    rdr(10'h0ff);
    chk("unmapped", {30'h0000_0000, rs}, {30'h0000_0000, RESP_SLVERR});
    wr(10'h0ff, 16'h0000);
    chk("unmapped_wr", {30'h0000_0000, s_axi_bresp}, {30'h0000_0000, RESP_SLVERR});
    foreach (rows[i]) begin
      wr(rows[i].idx, rows[i].d);
      rchk("reg_row", rows[i].idx, rows[i].e);
    end
    tick_run(16'h0000, 9, 11);
    tick_run(16'h0001, 19, 21);
    wr(IDX_CONFIG, 16'h0000);
    wr(IDX_COUNT, 16'h0000);
    wr(IDX_CTRL, 16'h0006);
    pins.falls(5);
    rchk("ext_count", IDX_COUNT, 16'h0005);
    // overflow from an external count with reload
    wr(IDX_IRQ_MASK, 16'h0001);
    wr(IDX_RELOAD, 16'h1230);
    wr(IDX_COUNT, 16'hfffe);
    wr(IDX_MODE, 16'h0002);
    pins.falls(2);
    rchk("ovf_reload", IDX_COUNT, 16'h1230);
    rchk("ovf_flag", IDX_CTRL, 16'h0086);
    chk("irq_set", {31'h0000_0000, irq}, 32'h0000_0001);
    chk("out_toggle", {31'h0000_0000, timer_out}, 32'h0000_0001);
    wr(IDX_CTRL, 16'h0006);
    rchk("flag_clr", IDX_CTRL, 16'h0006);
    wr(IDX_IRQ_STAT, 16'h0001);
    chk("irq_clr", {31'h0000_0000, irq}, 32'h0000_0000);
    // trigger ignored while disabled, then capture
    wr(IDX_RELOAD, 16'h1111);
    wr(IDX_COUNT, 16'h0022);
    pins.trig_fall();
    rchk("trig_off", IDX_RELOAD, 16'h1111);
    rchk("trig_off_stat", IDX_IRQ_STAT, 16'h0000);
    wr(IDX_CTRL, 16'h000f);
    pins.trig_fall();
    rchk("capture", IDX_RELOAD, 16'h0022);
    rchk("trig_flag", IDX_CTRL, 16'h004f);
    rchk("trig_stat", IDX_IRQ_STAT, 16'h0002);
    chk("irq_masked", {31'h0000_0000, irq}, 32'h0000_0000);
    // trigger edge with capture select clear reloads the count
    wr(IDX_COUNT, 16'h0100);
    wr(IDX_CTRL, 16'h000e);
    pins.trig_fall();
    rchk("trig_reload", IDX_COUNT, 16'h0022);
    wr(IDX_IRQ_STAT, 16'h0003);
    // receive baud from our overflow, transmit from timer 1
    wr(IDX_COUNT, 16'hffff);
    wr(IDX_CTRL, 16'h0026);
    pins.falls(1);
    rchk("baud_no_flag", IDX_CTRL, 16'h0026);
    rchk("baud_reload", IDX_COUNT, 16'h0022);
    chk("rx_from_ovf", rx_seen, 32'h0000_0001);
    chk("out_toggle2", {31'h0000_0000, timer_out}, 32'h0000_0000);
    pins.t1_pulse();
    rchk("baud_stat", IDX_IRQ_STAT, 16'h0000);
    chk("tx_from_t1", tx_seen, 32'h0000_0001);
    chk("rx_not_t1", rx_seen, 32'h0000_0001);
    // down count with the direction pin low
    wr(IDX_CTRL, 16'h0000);
    wr(IDX_MODE, 16'h0001);
    wr(IDX_COUNT, 16'h0005);
    pins.set_trig(1'b0);
    wr(IDX_CTRL, 16'h0006);
    pins.falls(1);
    rchk("down", IDX_COUNT, 16'h0004);
    wr(IDX_RELOAD, 16'h0004);
    pins.falls(1);
    rchk("down_wrap", IDX_COUNT, 16'hffff);
    // answers left waiting a cycle so the hold checks see a stalled channel
    s_axi_bready <= 1'b0;
    s_axi_rready <= 1'b0;
    wr(IDX_RELOAD, 16'h0055);
    chk("stall_bresp", {30'h0000_0000, s_axi_bresp}, {30'h0000_0000, RESP_OKAY});
    s_axi_bready <= 1'b1;
    @(posedge aclk);
    rdr(IDX_RELOAD);
    s_axi_rready <= 1'b1;
    @(posedge aclk);
    rd = s_axi_rdata;
    chk("stall_read", rd, 32'h0000_0055);
    aresetn <= 1'b0;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    rchk("ctrl_rst2", IDX_CTRL, 16'h0000);
    rchk("mode_rst2", IDX_MODE, 16'h0000);
    tally_and_finish();
  end
endmodule : timer2_control_logic_bench
`default_nettype wire
